/* File: core/xdm_top.v */
// data-space window decoder, access policy and global control register
`timescale 1ns/1ps
`include "xdm_defs.vh"
module xdm_top (
  core_clk,
  rst,
  clk48_en,
  reset_req,
  mcu_req,
  mcu_we,
  mcu_addr,
  mcu_wdata,
  mcu_rdata,
  mcu_ack,
  dma_req,
  dma_we,
  dma_upd,
  dma_addr,
  dma_wdata,
  dma_rdata,
  dma_ack,
  dma_denied,
  bmgr_req,
  bmgr_we,
  bmgr_upd,
  bmgr_addr,
  bmgr_wdata,
  bmgr_rdata,
  bmgr_ack,
  bmgr_denied,
  mcu_clk_en,
  mcu_clk_24,
  clock_output_pin,
  clock_output_pin_oe_n,
  reset_output_pin
);
  input wire core_clk;
  input wire rst;
  input wire clk48_en;
  input wire reset_req;
  input wire mcu_req;
  input wire mcu_we;
  input wire [15:0] mcu_addr;
  input wire [7:0] mcu_wdata;
  output reg [7:0] mcu_rdata;
  output reg mcu_ack;
  input wire dma_req;
  input wire dma_we;
  input wire dma_upd;
  input wire [15:0] dma_addr;
  input wire [7:0] dma_wdata;
  output reg [7:0] dma_rdata;
  output reg dma_ack;
  output reg dma_denied;
  input wire bmgr_req;
  input wire bmgr_we;
  input wire bmgr_upd;
  input wire [15:0] bmgr_addr;
  input wire [7:0] bmgr_wdata;
  output reg [7:0] bmgr_rdata;
  output reg bmgr_ack;
  output reg bmgr_denied;
  output reg mcu_clk_en;
  output wire mcu_clk_24;
  output reg clock_output_pin;
  output wire clock_output_pin_oe_n;
  output reg reset_output_pin;

  // ---------------------------------------------------------------
  // region decode
  // ---------------------------------------------------------------
  localparam M_MCU = 2'h0;
  localparam M_DMA = 2'h1;
  localparam M_BMGR = 2'h2;

  // returns 1 when master m may touch address a; upd marks a
  // descriptor update
  function allowed;
    input [1:0] m;
    input [15:0] a;
    input upd;
    reg ep0r;
    reg datr;
    begin
      ep0r = (a >= `XDM_REG_BASE) && (a <= `XDM_EP0_REG_TOP);
      datr = (a == `XDM_DMA_DATA_LO) || (a == `XDM_DMA_DATA_HI) ||
             (a == `XDM_DMA_DATA2_LO) || (a == `XDM_DMA_DATA2_HI) ||
             (a == `XDM_PP_DATA);
      if (a < `XDM_WIN_BASE) begin
        allowed = 1'b0;
      end else if (m == M_MCU) begin
        allowed = 1'b1;
      end else if (a >= `XDM_REG_BASE) begin
        allowed = ep0r || ((m == M_DMA) && datr);
      end else if (a >= `XDM_DESC_BASE) begin
        allowed = upd;
      end else if (a >= `XDM_SETUP_BASE) begin
        allowed = (m == M_BMGR);
      end else begin
        allowed = 1'b1;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // arbitration: processor, then dma, then buffer manager
  // ---------------------------------------------------------------
  reg [1:0] gnt;
  reg gvalid;
  reg g_we;
  reg [15:0] g_addr;
  reg [7:0] g_wdata;
  reg g_ok;
  always @* begin
    gnt = M_MCU;
    gvalid = 1'b0;
    g_we = 1'b0;
    g_addr = 16'h0000;
    g_wdata = 8'h00;
    g_ok = 1'b0;
    if (mcu_req) begin
      gvalid = 1'b1;
      g_we = mcu_we;
      g_addr = mcu_addr;
      g_wdata = mcu_wdata;
      g_ok = allowed(M_MCU, mcu_addr, 1'b0);
    end else if (dma_req) begin
      gnt = M_DMA;
      gvalid = 1'b1;
      g_we = dma_we;
      g_addr = dma_addr;
      g_wdata = dma_wdata;
      g_ok = allowed(M_DMA, dma_addr, dma_upd);
    end else if (bmgr_req) begin
      gnt = M_BMGR;
      gvalid = 1'b1;
      g_we = bmgr_we;
      g_addr = bmgr_addr;
      g_wdata = bmgr_wdata;
      g_ok = allowed(M_BMGR, bmgr_addr, bmgr_upd);
    end
  end

  wire is_gc = (g_addr == `XDM_GCTL_ADR);
  wire is_reg = (g_addr >= `XDM_REG_BASE);
  // other units' registers live elsewhere; here they read zero
  wire ram_we = gvalid && g_ok && g_we && !is_reg;

  wire [7:0] ram_rdata;
  xdm_ram u_ram (
    .core_clk(core_clk),
    .we(ram_we),
    .addr(g_addr[`XDM_RAM_AW-1:0]),
    .wdata(g_wdata),
    .rdata(ram_rdata)
  );

  // ---------------------------------------------------------------
  // global control register
  // ---------------------------------------------------------------
  reg [7:0] gc_r;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gc_r <= `XDM_GC_RESET;
    end else if (gvalid && g_ok && g_we && is_gc) begin
      gc_r <= g_wdata & `XDM_GC_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // answer path: one cycle after the request
  // ---------------------------------------------------------------
  reg [1:0] q_gnt;
  reg q_valid;
  reg q_ok;
  reg q_rd;
  reg q_reg;
  reg q_gc;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q_gnt <= M_MCU;
      q_valid <= 1'b0;
      q_ok <= 1'b0;
      q_rd <= 1'b0;
      q_reg <= 1'b0;
      q_gc <= 1'b0;
    end else begin
      q_gnt <= gnt;
      q_valid <= gvalid;
      q_ok <= g_ok;
      q_rd <= !g_we;
      q_reg <= is_reg;
      q_gc <= is_gc;
    end
  end

  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    if (q_ok && q_rd) begin
      if (q_gc) begin
        rd_val = gc_r & `XDM_GC_WMASK;
      end else if (!q_reg) begin
        rd_val = ram_rdata;
      end
    end
  end

  always @* begin
    mcu_ack = q_valid && (q_gnt == M_MCU);
    dma_ack = q_valid && (q_gnt == M_DMA);
    bmgr_ack = q_valid && (q_gnt == M_BMGR);
    dma_denied = dma_ack && !q_ok;
    bmgr_denied = bmgr_ack && !q_ok;
    mcu_rdata = mcu_ack ? rd_val : 8'h00;
    dma_rdata = dma_ack ? rd_val : 8'h00;
    bmgr_rdata = bmgr_ack ? rd_val : 8'h00;
  end

  // ---------------------------------------------------------------
  // clock outputs from the 48 MHz enable
  // ---------------------------------------------------------------
  reg [2:0] div_r;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_r <= 3'h0;
    end else if (clk48_en) begin
      div_r <= div_r + 3'h1;
    end
  end

  // processor clock enable: every 4th (12 MHz) or 2nd (24 MHz) tick
  assign mcu_clk_24 = gc_r[`XDM_B_MCU24];
  always @* begin
    if (gc_r[`XDM_B_MCU24]) begin
      mcu_clk_en = clk48_en && div_r[0];
    end else begin
      mcu_clk_en = clk48_en && (div_r[1:0] == 2'h3);
    end
  end

  wire [1:0] fsel = gc_r[`XDM_B_FSEL_HI:`XDM_B_FSEL_LO];
  reg clk_next;
  always @* begin
    case (fsel)
      `XDM_FS_48: clk_next = clk48_en;
      `XDM_FS_24: clk_next = div_r[0];
      `XDM_FS_12: clk_next = div_r[1];
      `XDM_FS_6: clk_next = div_r[2];
      default: clk_next = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clock_output_pin <= 1'b0;
      reset_output_pin <= 1'b0;
    end else begin
      clock_output_pin <= clk_next & ~gc_r[`XDM_B_OE_N];
      // polarity bit 1: asserted high; 0: asserted low
      reset_output_pin <= reset_req ~^ gc_r[`XDM_B_RPOL];
    end
  end
  assign clock_output_pin_oe_n = gc_r[`XDM_B_OE_N];
endmodule // xdm_top

/* File: core/xdm_defs.vh */
// constants for the data-space decoder and global control register
`ifndef XDM_DEFS_VH
`define XDM_DEFS_VH
`define XDM_AW 16
`define XDM_WIN_BASE 16'hF800
`define XDM_BUF_TOP 16'hFEEF
`define XDM_EP0_BASE 16'hFEF0
`define XDM_SETUP_BASE 16'hFF00
`define XDM_DESC_BASE 16'hFF08
`define XDM_REG_BASE 16'hFF80
`define XDM_EP0_REG_TOP 16'hFF83
`define XDM_GCTL_ADR 16'hFF91
`define XDM_DMA_DATA_LO 16'hFFA0
`define XDM_DMA_DATA_HI 16'hFFA1
`define XDM_DMA_DATA2_LO 16'hFFB0
`define XDM_DMA_DATA2_HI 16'hFFB1
`define XDM_PP_DATA 16'hFF9E
`define XDM_RAM_AW 11
`define XDM_RAM_DEPTH 2048
`define XDM_GC_RESET 8'h08
`define XDM_GC_WMASK 8'hF8
`define XDM_B_MCU24 7
`define XDM_B_FSEL_HI 6
`define XDM_B_FSEL_LO 5
`define XDM_B_OE_N 4
`define XDM_B_RPOL 3
`define XDM_FS_48 2'h0
`define XDM_FS_24 2'h1
`define XDM_FS_12 2'h2
`define XDM_FS_6 2'h3
`endif

/* File: core/xdm_ram.v */
// byte memory behind the data-space window, registered read data
`timescale 1ns/1ps
`include "xdm_defs.vh"
module xdm_ram (
  core_clk,
  we,
  addr,
  wdata,
  rdata
);
  input wire core_clk;
  input wire we;
  input wire [`XDM_RAM_AW-1:0] addr;
  input wire [7:0] wdata;
  output reg [7:0] rdata;

  reg [7:0] mem [0:`XDM_RAM_DEPTH-1];

  always @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // xdm_ram

/* File: dv/xdm_tick_src.sv */
// partner model: 48 MHz tick reference seen by the decoder
`timescale 1ns/1ps
module xdm_tick_src (
  input wire core_clk,
  input wire rst,
  output logic clk48_en = 1'b0
);
  // one tick every other edge keeps divided outputs visibly periodic
  always @(posedge core_clk or posedge rst)
    if (rst) clk48_en <= 1'b0;
    else clk48_en <= ~clk48_en;
endmodule // xdm_tick_src

/* File: dv/xdm_checker.sv */
// port assertions for the data-space decoder and control register
`timescale 1ns/1ps
module xdm_checker (
  input wire core_clk,
  input wire rst,
  input wire mcu_req,
  input wire mcu_we,
  input wire mcu_ack,
  input wire [15:0] mcu_addr,
  input wire [15:0] dma_addr,
  input wire [15:0] bmgr_addr,
  input wire [7:0] mcu_wdata,
  input wire [7:0] mcu_rdata,
  input wire [7:0] dma_rdata,
  input wire dma_req,
  input wire dma_upd,
  input wire dma_denied,
  input wire bmgr_req,
  input wire bmgr_denied,
  input wire mcu_clk_24,
  input wire clock_output_pin,
  input wire clock_output_pin_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire dma_won = dma_req && !mcu_req;
  wire bmgr_won = bmgr_req && !mcu_req && !dma_req;
  wire gc_wr = mcu_req && mcu_we && mcu_addr == 16'hFF91;
  a_mcu_ack_next: assert property (mcu_req |=> mcu_ack)
    else $error("mcu ack missing");
  a_clk24_bit: assert property (
    gc_wr |=> mcu_clk_24 == $past(mcu_wdata[7]))
    else $error("clock select bit not applied");
  a_pin_quiet: assert property (
    clock_output_pin_oe_n && $past(clock_output_pin_oe_n)
    |-> !clock_output_pin) else $error("clock out while disabled");
  a_setup_dma: assert property (
    dma_won && dma_addr[15:3] == 13'h1FE0
    |=> dma_denied && dma_rdata == 8'h00) else $error("setup open");
  a_desc_noupd: assert property (
    dma_won && !dma_upd && dma_addr >= 16'hFF08 && dma_addr <= 16'hFF7F
    |=> dma_denied) else $error("descriptor access not refused");
  a_low_deny: assert property (
    bmgr_won && bmgr_addr < 16'hF800 |=> bmgr_denied)
    else $error("outside window not refused");
  a_reg_bmgr: assert property (
    bmgr_won && bmgr_addr > 16'hFF83 |=> bmgr_denied)
    else $error("register range open to buffer manager");
  a_mcu_low: assert property (
    mcu_req && !mcu_we && mcu_addr < 16'hF800 |=> mcu_rdata == 8'h00)
    else $error("outside window read not zero");
  a_idle_zero: assert property (!mcu_ack |-> mcu_rdata == 8'h00)
    else $error("read data without ack");
  c_dma_deny: cover property (dma_denied);
  c_bmgr_deny: cover property (bmgr_denied);
  c_clk24: cover property ($rose(mcu_clk_24));
endmodule // xdm_checker
bind xdm_top xdm_checker u_chk (.core_clk, .rst, .mcu_req, .mcu_we,
  .mcu_ack, .mcu_addr, .dma_addr, .bmgr_addr, .mcu_wdata, .mcu_rdata,
  .dma_rdata, .dma_req, .dma_upd, .dma_denied, .bmgr_req, .bmgr_denied,
  .mcu_clk_24, .clock_output_pin, .clock_output_pin_oe_n);

/* File: dv/tb_external_data_space_map_and_global_control.sv */
// self-checking bench for the data-space decoder and control register
`timescale 1ns/1ps
module tb_external_data_space_map_and_global_control;
  logic core_clk = 0, rst = 1, reset_req = 0, clk48_en;
  logic [2:0] rq = 0, wv = 0, up = 0, ak, dn;
  logic [15:0] ad [3] = '{default: 16'h0000};
  logic [7:0] wd [3] = '{default: 8'h00};
  logic [7:0] rd [3];
  logic mce, m24, cpin, coe, rpin;
  int bad_count = 0, compares = 0, cyc = 0, ncl = 0, nme = 0, m12;
  int r [4];
  always #12.5 core_clk = ~core_clk;
  xdm_tick_src prt (.core_clk(core_clk), .rst(rst), .clk48_en(clk48_en));
  xdm_top dut (.core_clk(core_clk), .rst(rst), .clk48_en(clk48_en),
    .reset_req(reset_req), .mcu_req(rq[0]), .mcu_we(wv[0]),
    .mcu_addr(ad[0]), .mcu_wdata(wd[0]), .mcu_rdata(rd[0]),
    .mcu_ack(ak[0]), .dma_req(rq[1]), .dma_we(wv[1]), .dma_upd(up[1]),
    .dma_addr(ad[1]), .dma_wdata(wd[1]), .dma_rdata(rd[1]),
    .dma_ack(ak[1]), .dma_denied(dn[1]), .bmgr_req(rq[2]),
    .bmgr_we(wv[2]), .bmgr_upd(up[2]), .bmgr_addr(ad[2]),
    .bmgr_wdata(wd[2]), .bmgr_rdata(rd[2]), .bmgr_ack(ak[2]),
    .bmgr_denied(dn[2]),
    .mcu_clk_en(mce), .mcu_clk_24(m24), .clock_output_pin(cpin),
    .clock_output_pin_oe_n(coe), .reset_output_pin(rpin));
  always @(posedge cpin) ncl++;
  always @(posedge core_clk) if (mce === 1'b1) nme++;
  task chk(input [15:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  // one byte access; ack and read data are looked at in their one cycle
  task acc(input int m, input w, u, input [15:0] a, input [7:0] d, e,
    input den);
    @(posedge core_clk);
    rq[m] <= 1; wv[m] <= w; up[m] <= u; ad[m] <= a; wd[m] <= d;
    @(posedge core_clk);
    rq[m] <= 0;
    #1 chk(ak[m], 1);
    if (!w) chk(rd[m], e);
    if (m > 0) chk(dn[m], den);
  endtask
  task gc(input [7:0] v);
    acc(0, 1, 0, 16'hFF91, v, 0, 0);
  endtask
  task span;
    @(posedge core_clk);
    #1 ncl = 0;
    nme = 0;
    repeat (192) @(posedge core_clk);
    #1;
  endtask
  task finish_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 0;
    acc(0, 0, 0, 16'hFF91, 0, 8'h08, 0);
    chk(m24, 0);
    chk(rpin, 0);
    @(posedge core_clk) reset_req <= 1;
    @(posedge core_clk);
    #1 chk(rpin, 1);
    gc(8'hFF);
    acc(0, 0, 0, 16'hFF91, 0, 8'hF8, 0);
    chk(coe, 1);
    span;
    chk(ncl, 0);
    gc(8'h00);
    @(posedge core_clk);
    #1 chk(rpin, 0);
    chk(coe, 0);
    for (int f = 0; f < 4; f++) begin
      gc({1'b0, f[1:0], 5'h00});
      span;
      r[f] = ncl;
    end
    m12 = nme;
    for (int f = 0; f < 3; f++)
      chk(r[f] >= 2 * r[f+1] - 1 && r[f] <= 2 * r[f+1] + 1, 1);
    chk(r[3] > 2, 1);
    gc(8'h80);
    chk(m24, 1);
    span;
    chk(nme >= 2 * m12 - 1 && nme <= 2 * m12 + 1 && m12 > 2, 1);
    acc(0, 1, 0, 16'hF800, 8'hAA, 0, 0);
    acc(1, 0, 0, 16'hF800, 0, 8'hAA, 0);
    acc(2, 1, 0, 16'hFEEF, 8'h55, 0, 0);
    acc(0, 0, 0, 16'hFEEF, 0, 8'h55, 0);
    acc(0, 1, 0, 16'hFF00, 8'h33, 0, 0);
    acc(1, 1, 0, 16'hFF00, 8'hCC, 0, 1);
    acc(2, 0, 0, 16'hFF00, 0, 8'h33, 0);
    acc(1, 0, 0, 16'hFF08, 0, 0, 1);
    acc(1, 1, 1, 16'hFF08, 8'h5A, 0, 0);
    acc(2, 0, 1, 16'hFF08, 0, 8'h5A, 0);
    acc(1, 0, 0, 16'hFFA0, 0, 0, 0);
    acc(1, 0, 0, 16'hFF91, 0, 0, 1);
    acc(2, 0, 0, 16'hFF80, 0, 0, 0);
    acc(2, 0, 0, 16'hFFA0, 0, 0, 1);
    acc(2, 0, 0, 16'hF7FF, 0, 0, 1);
    acc(0, 0, 0, 16'hF7FF, 0, 0, 0);
    acc(0, 0, 0, 16'hFF85, 0, 0, 0);
    finish_test;
  end
endmodule // tb_external_data_space_map_and_global_control
